/* design/sas_pkg.sv */
// Package: constants and types for the converter sequencer
package sas_pkg;
  localparam int unsigned RES_BITS = 10;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned CLK_MHZ = 250;
  // Peripheral clock period in system clocks
  localparam int unsigned PCLK_DIV = 8;
  // Sampling states per clock_select setting, slowest first
  localparam logic [8:0] SPL_STATES_0 = 9'h100;
  localparam logic [8:0] SPL_STATES_1 = 9'h080;
  localparam logic [8:0] SPL_STATES_2 = 9'h040;
  localparam logic [8:0] SPL_STATES_3 = 9'h020;
  // Start delay minimum states per clock_select
  localparam logic [5:0] DLY_STATES_0 = 6'h1F;
  localparam logic [5:0] DLY_STATES_1 = 6'h0F;
  localparam logic [5:0] DLY_STATES_2 = 6'h07;
  localparam logic [5:0] DLY_STATES_3 = 6'h03;
  // Fixed scan conversion time in states
  localparam logic [10:0] SCAN_STATES_0 = 11'h400;
  localparam logic [10:0] SCAN_STATES_1 = 11'h200;
  localparam logic [10:0] SCAN_STATES_2 = 11'h100;
  localparam logic [10:0] SCAN_STATES_3 = 11'h080;
  // Shortest single conversion in states, start delay included
  localparam logic [10:0] CONV_STATES_0 = 11'h400;
  localparam logic [10:0] CONV_STATES_1 = 11'h203;
  localparam logic [10:0] CONV_STATES_2 = 11'h103;
  localparam logic [10:0] CONV_STATES_3 = 11'h083;
  // Trigger source encodings
  localparam logic [1:0] TRG_BOTH = 2'h0;
  localparam logic [1:0] TRG_PIN = 2'h1;
  localparam logic [1:0] TRG_TIMER = 2'h2;
  localparam logic [1:0] TRG_NONE = 2'h3;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_WIDTH = RES_BITS + 2;

  typedef enum logic [3:0] {
    SAS_IDLE = 4'h1,
    SAS_DELAY = 4'h2,
    SAS_SAMPLE = 4'h4,
    SAS_CONVERT = 4'h8
  } sas_state_t;
endpackage : sas_pkg

/* design/sas_fifo.sv */
// Result FIFO between the sequencer and the transfer side
`timescale 1ns/100ps
`default_nettype none
module sas_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Write side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Read side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sas_fifo_st_t;

  sas_fifo_st_t s_reg;
  sas_fifo_st_t s_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_wr;
  logic do_rd;

  assign in_ready = (s_reg.cnt != DEPTH[AW:0]);
  assign out_valid = (s_reg.cnt != '0);
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_data = mem[s_reg.rp];

  always_comb begin
    s_next = s_reg;
    if (do_wr) begin
      s_next.wp = s_reg.wp + 1'b1;
    end
    if (do_rd) begin
      s_next.rp = s_reg.rp + 1'b1;
    end
    s_next.cnt = s_reg.cnt + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Storage has no reset; only pointers and count need a defined value
  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[s_reg.wp] <= in_data;
    end
  end
endmodule : sas_fifo
`default_nettype wire

/* design/sas_sequencer.sv */
// Successive-approximation converter sequencer with result FIFO
// Contract
// RQ1 - Each sample resolves by successive approximation to ten bits.
// RQ2 - Software clears start bit before changing mode or channel.
// RQ3 - Start bit may be set in the same write changing mode or channel.
// RQ4 - Single mode converts the selected channel once per start, any source.
// RQ5 - Single result lands in that channel's data register.
// RQ6 - Completion sets end flag; interrupt requested when enable is set.
// RQ7 - Single mode: start bit holds during conversion, self-clears, then idle.
// RQ8 - Scans start at lowest selected channel and ascend.
// RQ9 - Scan stores each channel result as soon as it finishes.
// RQ10 - Continuous scan flags after full pass, then restarts at first channel.
// RQ11 - Continuous scan repeats while start bit is one; clearing stops it.
// RQ12 - Single-cycle scan: one pass, flag, self-clear; clear mid-pass aborts.
// RQ13 - Start delay then sampling precede conversion after start.
// RQ14 - Sampling 256/128/64/32 states by clock_select; single total bounded.
// RQ15 - Scan: first like single, later ones fixed 1024/512/256/128 states.
// RQ16 - Enabled timer request sets start bit with software timing.
// RQ17 - Source 00 or 01: pin falling edge sets the start bit.
// RQ18 - Transfer unit moving the data clears the end flag.
// RQ19 - Unit zero activates transfer controller only; unit one either.
// RQ20 - Source select: 00 both, 01 pin, 10 timer, 11 none.
// RQ21 - scan_repeat_select: 0 single pass, 1 continuous; ignored outside scan.
// RQ22 - Interrupt output high while end flag and enable are both one.
// RQ23 - Trigger during a running conversion does not restart the pass.
`timescale 1ns/100ps
`default_nettype none
module sas_sequencer
  import sas_pkg::*;
#(
  parameter int unsigned CH_COUNT = NUM_CH,
  parameter bit UNIT_ONE = 1'b1,
  parameter int unsigned FDEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control from software
  input wire logic start_conversion_set,
  input wire logic start_conversion_clear,
  input wire logic scan_mode,
  input wire logic scan_repeat_select,
  input wire logic [1:0] channel_select,
  input wire logic [1:0] clock_select,
  input wire logic [1:0] trigger_source_select,
  input wire logic end_interrupt_enable,
  input wire logic end_flag_clear,
  // Triggers
  input wire logic timer_request,
  input wire logic ext_trigger_input_n,
  // Analog front end: comparator and trial code
  input wire logic comparator_high,
  output logic [RES_BITS-1:0] trial_code,
  output logic [1:0] mux_channel,
  output logic sample_hold,
  // Status
  output logic start_conversion_bit,
  output logic conversion_end_flag,
  output logic busy,
  output logic [CH_COUNT*RES_BITS-1:0] channel_data,
  // Interrupt and transfer activation
  output logic conversion_end_interrupt,
  input wire logic dtc_select,
  output logic dtc_request,
  output logic memory_access_controller_request,
  input wire logic transfer_done,
  // Result stream
  output logic result_valid,
  input wire logic result_ready,
  output logic [FIFO_WIDTH-1:0] result_data
);
  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    sas_state_t st;
    logic start;
    logic flag;
    logic first_done;
    logic [1:0] ch;
    logic [1:0] last_ch;
    logic [2:0] pdiv;
    logic [10:0] cnt;
    logic [3:0] bitn;
    logic [RES_BITS-1:0] sar;
    logic [CH_COUNT*RES_BITS-1:0] data;
    logic push;
    logic [FIFO_WIDTH-1:0] push_data;
    logic pin_s1;
    logic pin_s2;
    logic pin_old;
  } sas_seq_st_t;

  sas_seq_st_t s_reg;
  sas_seq_st_t s_next;
  logic tick;
  logic pin_fall;
  logic trig_go;
  logic fifo_ready;
  logic [8:0] spl_states;
  logic [5:0] dly_states;
  logic [10:0] scan_states;
  logic [10:0] bit_states;
  logic [10:0] conv_states;
  logic [10:0] step_total;
  logic [10:0] lead_states;

  assign tick = (s_reg.pdiv == 3'(PCLK_DIV - 1));
  assign pin_fall = s_reg.pin_old && !s_reg.pin_s2;
  assign trig_go = (pin_fall && (trigger_source_select == TRG_BOTH
                                 || trigger_source_select == TRG_PIN))                // [RQ17]
                || (timer_request && (trigger_source_select == TRG_BOTH
                                      || trigger_source_select == TRG_TIMER));        // [RQ16] [RQ20]

  always_comb begin
    case (clock_select)                                                              // [RQ14] [RQ15]
      2'h0: begin
        spl_states = SPL_STATES_0;
        dly_states = DLY_STATES_0;
        scan_states = SCAN_STATES_0;
        conv_states = CONV_STATES_0;
      end
      2'h1: begin
        spl_states = SPL_STATES_1;
        dly_states = DLY_STATES_1;
        scan_states = SCAN_STATES_1;
        conv_states = CONV_STATES_1;
      end
      2'h2: begin
        spl_states = SPL_STATES_2;
        dly_states = DLY_STATES_2;
        scan_states = SCAN_STATES_2;
        conv_states = CONV_STATES_2;
      end
      default: begin
        spl_states = SPL_STATES_3;
        dly_states = DLY_STATES_3;
        scan_states = SCAN_STATES_3;
        conv_states = CONV_STATES_3;
      end
    endcase
  end

  // Ten bit steps share what delay and sampling leave of the shortest single
  // conversion; later scan conversions fill the fixed scan figure. The first
  // step takes the division remainder so the total comes out exact.
  always_comb begin
    if (scan_mode && s_reg.first_done) begin
      step_total = scan_states - 11'(spl_states);                                     // [RQ15]
    end else begin
      step_total = conv_states - 11'(dly_states) - 11'(spl_states);                   // [RQ14]
    end
    bit_states = step_total / 11'h00A;
    lead_states = step_total - (bit_states * 11'h00A) + bit_states;
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    s_next = s_reg;
    s_next.push = 1'b0;
    s_next.pin_s1 = ext_trigger_input_n;
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.pin_old = s_reg.pin_s2;
    s_next.pdiv = tick ? 3'h0 : s_reg.pdiv + 3'h1;

    if (end_flag_clear || (transfer_done && s_reg.flag)) begin
      s_next.flag = 1'b0;                                                             // [RQ18]
    end
    if (start_conversion_clear) begin
      s_next.start = 1'b0;
    end

    case (s_reg.st)
      SAS_IDLE: begin
        if (start_conversion_set || trig_go) begin                                    // [RQ3] [RQ4]
          s_next.start = 1'b1;
          s_next.first_done = 1'b0;
          s_next.ch = scan_mode ? 2'h0 : channel_select;                              // [RQ8]
          s_next.last_ch = channel_select;
          s_next.cnt = 11'(dly_states);
          s_next.st = SAS_DELAY;                                                      // [RQ13]
        end
      end
      SAS_DELAY: begin
        if (tick) begin
          if (s_reg.cnt == 11'h0) begin
            s_next.cnt = 11'(spl_states) - 11'h1;
            s_next.st = SAS_SAMPLE;
          end else begin
            s_next.cnt = s_reg.cnt - 11'h1;
          end
        end
      end
      SAS_SAMPLE: begin
        if (tick) begin
          if (s_reg.cnt == 11'h0) begin
            s_next.cnt = lead_states - 11'h1;
            s_next.bitn = 4'(RES_BITS - 1);
            s_next.sar = RES_BITS'(1) << (RES_BITS - 1);
            s_next.st = SAS_CONVERT;
          end else begin
            s_next.cnt = s_reg.cnt - 11'h1;
          end
        end
      end
      SAS_CONVERT: begin
        if (tick) begin
          if (s_reg.cnt != 11'h0) begin
            s_next.cnt = s_reg.cnt - 11'h1;
          end else begin
            // Keep or drop the trial bit, then try the next one down
            if (!comparator_high) begin
              s_next.sar[s_reg.bitn] = 1'b0;                                          // [RQ1]
            end
            if (s_reg.bitn != 4'h0) begin
              s_next.sar[s_reg.bitn - 4'h1] = 1'b1;
              s_next.bitn = s_reg.bitn - 4'h1;
              s_next.cnt = bit_states - 11'h1;
            end else begin
              s_next.data[s_reg.ch*RES_BITS +: RES_BITS] = s_next.sar;                // [RQ5] [RQ9]
              s_next.push = 1'b1;
              s_next.push_data = {s_reg.ch, s_next.sar};
              s_next.first_done = 1'b1;
              if (!scan_mode) begin
                s_next.flag = 1'b1;                                                   // [RQ6]
                s_next.start = 1'b0;                                                  // [RQ7]
                s_next.st = SAS_IDLE;
              end else if (s_reg.ch != s_reg.last_ch) begin
                s_next.ch = s_reg.ch + 2'h1;                                          // [RQ8]
                s_next.cnt = 11'(spl_states) - 11'h1;
                s_next.st = SAS_SAMPLE;
              end else begin
                s_next.flag = 1'b1;                                                   // [RQ10]
                s_next.ch = 2'h0;
                if (scan_repeat_select) begin                                         // [RQ21]
                  s_next.cnt = 11'(spl_states) - 11'h1;
                  s_next.st = SAS_SAMPLE;                                             // [RQ11]
                end else begin
                  s_next.start = 1'b0;                                                // [RQ12]
                  s_next.st = SAS_IDLE;
                end
              end
            end
          end
        end
      end
      default: begin
        s_next.st = SAS_IDLE;
      end
    endcase

    // Clearing the start bit aborts any pass; triggers while busy are ignored
    if (start_conversion_clear && s_reg.st != SAS_IDLE) begin                         // [RQ11] [RQ12] [RQ23]
      s_next.st = SAS_IDLE;
      s_next.start = 1'b0;
    end
    // A finish flag beats a same-cycle clear
    if (s_next.push && (s_reg.ch == s_reg.last_ch || !scan_mode)) begin
      s_next.flag = 1'b1;
    end
    // Hold a refused word until the FIFO takes it; a newer result meanwhile is lost
    if (s_reg.push && !fifo_ready) begin
      s_next.push = 1'b1;
      s_next.push_data = s_reg.push_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{st: SAS_IDLE, pin_s1: 1'b1, pin_s2: 1'b1, pin_old: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Result stream
  // ==========================================================================
  sas_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FDEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(s_reg.push),
    .in_ready(fifo_ready),
    .in_data(s_reg.push_data),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(result_data)
  );

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign trial_code = s_reg.sar;
  assign mux_channel = s_reg.ch;
  assign sample_hold = (s_reg.st == SAS_SAMPLE);
  assign start_conversion_bit = s_reg.start;                                          // [RQ7]
  assign conversion_end_flag = s_reg.flag;
  assign busy = (s_reg.st != SAS_IDLE);
  assign channel_data = s_reg.data;
  assign conversion_end_interrupt = s_reg.flag && end_interrupt_enable;               // [RQ22]
  // Unit zero cannot reach the memory access controller
  assign dtc_request = conversion_end_interrupt && (dtc_select || !UNIT_ONE);         // [RQ19]
  assign memory_access_controller_request = conversion_end_interrupt && !dtc_select && UNIT_ONE;          // [RQ19]
endmodule : sas_sequencer
`default_nettype wire

/* tb/sas_afe_model.sv */
// Behavioural analog front end: per-channel levels, hold and comparator
`timescale 1ns/100ps
`default_nettype none
module sas_afe_model
  import sas_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Input levels, channel n at bits [10n+9:10n]
  input wire logic [NUM_CH*RES_BITS-1:0] levels,
  // Sequencer side
  input wire logic [1:0] mux_channel,
  input wire logic sample_hold,
  input wire logic [RES_BITS-1:0] trial_code,
  output logic comparator_high
);
  logic [RES_BITS-1:0] held;
  // Hold follows the selected input only while sampling, frozen after
  always_ff @(posedge clk_sys) begin
    if (sample_hold) begin
      held <= levels[mux_channel*RES_BITS +: RES_BITS];
    end
  end
  assign comparator_high = (held >= trial_code);
endmodule : sas_afe_model
`default_nettype wire

/* tb/sas_sequencer_properties.sv */
// Concurrent checks on the sequencer's ports
`timescale 1ns/100ps
`default_nettype none
module sas_sequencer_properties
  import sas_pkg::*;
#(
  parameter bit UNIT_ONE = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Controls
  input wire logic start_conversion_set,
  input wire logic start_conversion_clear,
  input wire logic scan_mode,
  input wire logic [1:0] clock_select,
  input wire logic [1:0] trigger_source_select,
  input wire logic end_interrupt_enable,
  input wire logic end_flag_clear,
  input wire logic timer_request,
  input wire logic dtc_select,
  input wire logic transfer_done,
  // Observed outputs
  input wire logic sample_hold,
  input wire logic start_conversion_bit,
  input wire logic conversion_end_flag,
  input wire logic busy,
  input wire logic conversion_end_interrupt,
  input wire logic dtc_request,
  input wire logic memory_access_controller_request
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========
  // Sampling window length
  logic [11:0] spl_cnt_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      spl_cnt_reg <= 12'h000;
    end else begin
      spl_cnt_reg <= sample_hold ? spl_cnt_reg + 12'h001 : 12'h000;
    end
  end
  sequence s_quiet;
    !sample_hold [*8];
  endsequence
  sequence s_sampling;
    s_quiet ##[1:300] sample_hold;
  endsequence
  // ==========
  // Properties
  AST_IRQ_LEVEL: assert property (
    conversion_end_interrupt == (conversion_end_flag && end_interrupt_enable))
    else $error("interrupt level differs from flag and enable");
  AST_ROUTE: assert property (
    ((dtc_request || memory_access_controller_request) == conversion_end_interrupt)
    && !(dtc_request && memory_access_controller_request) && !(memory_access_controller_request && (dtc_select || !UNIT_ONE)))
    else $error("transfer request routing wrong");
  AST_FLAG_CLR: assert property (
    (end_flag_clear || transfer_done) && !busy |=> !conversion_end_flag)
    else $error("end flag not cleared");
  AST_SET_TAKEN: assert property (
    start_conversion_set && !busy |=> busy && start_conversion_bit)
    else $error("start not taken");
  AST_START_HOLDS: assert property (
    busy && !scan_mode |-> start_conversion_bit)
    else $error("start bit dropped during single conversion");
  AST_CLEAR_IDLE: assert property (
    start_conversion_clear |=> !busy && !start_conversion_bit)
    else $error("clear did not return to idle");
  AST_DELAY: assert property (
    $rose(busy) |-> s_sampling)
    else $error("start delay before sampling wrong");
  AST_SPL_LEN: assert property (
    $fell(sample_hold) && !$past(start_conversion_clear)
    |-> spl_cnt_reg == (12'h800 >> clock_select))
    else $error("sampling length wrong");
  AST_TRIG_OFF: assert property (
    (trigger_source_select == TRG_NONE || trigger_source_select == TRG_PIN)
    && timer_request && !busy && !start_conversion_set |=> !busy)
    else $error("disabled timer request started conversion");
endmodule : sas_sequencer_properties
bind sas_sequencer sas_sequencer_properties #(.UNIT_ONE(UNIT_ONE)) chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .start_conversion_set(start_conversion_set),
  .start_conversion_clear(start_conversion_clear), .scan_mode(scan_mode),
  .clock_select(clock_select), .trigger_source_select(trigger_source_select),
  .end_interrupt_enable(end_interrupt_enable), .end_flag_clear(end_flag_clear),
  .timer_request(timer_request), .dtc_select(dtc_select), .transfer_done(transfer_done),
  .sample_hold(sample_hold), .start_conversion_bit(start_conversion_bit),
  .conversion_end_flag(conversion_end_flag), .busy(busy),
  .conversion_end_interrupt(conversion_end_interrupt), .dtc_request(dtc_request),
  .memory_access_controller_request(memory_access_controller_request));
`default_nettype wire

/* tb/sas_sequencer_tb.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module sas_sequencer_tb
  import sas_pkg::*;
;
  localparam logic [39:0] LEVELS = {10'h3FF, 10'h2AA, 10'h155, 10'h000};
  localparam int TMIN [4] = '{1024, 515, 259, 131};
  localparam int TMAX [4] = '{1055, 530, 266, 134};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic set_p, clr_p, scan_mode, rep, en, flag_clr, tmr, pin_n, cmp, dtc_sel, done_p;
  logic ready, sh, start_bit, end_flag, busy, irq, dtc_req, memory_access_controller_req, rvalid, got_word;
  logic [1:0] ch, cs, src, mux;
  logic [9:0] trial;
  logic [39:0] chan_data;
  logic [11:0] rdata;
  logic [11:0] q [$];
  int bad_count = 0;
  int tests_run = 0;
  always #2 clk_sys = ~clk_sys;
  // ==========
  // Design and front end
  sas_sequencer #(.UNIT_ONE(1'b1)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .start_conversion_set(set_p),
    .start_conversion_clear(clr_p), .scan_mode(scan_mode), .scan_repeat_select(rep),
    .channel_select(ch), .clock_select(cs), .trigger_source_select(src),
    .end_interrupt_enable(en), .end_flag_clear(flag_clr), .timer_request(tmr),
    .ext_trigger_input_n(pin_n), .comparator_high(cmp), .trial_code(trial),
    .mux_channel(mux), .sample_hold(sh), .start_conversion_bit(start_bit),
    .conversion_end_flag(end_flag), .busy(busy), .channel_data(chan_data),
    .conversion_end_interrupt(irq), .dtc_select(dtc_sel), .dtc_request(dtc_req),
    .memory_access_controller_request(memory_access_controller_req), .transfer_done(done_p), .result_valid(rvalid),
    .result_ready(ready), .result_data(rdata));
  sas_afe_model afe_u (.clk_sys(clk_sys), .levels(LEVELS), .mux_channel(mux),
    .sample_hold(sh), .trial_code(trial), .comparator_high(cmp));
  always @(posedge clk_sys) begin
    if (rvalid === 1'b1 && ready === 1'b1) begin
      q.push_back(rdata);
      got_word = 1'b1;
    end
  end
  // ==========
  // Helpers
  function automatic logic [9:0] lvl(input int n);
    return LEVELS[n*10 +: 10];
  endfunction : lvl
  task automatic wrap_up;
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  task automatic fail(input string m);
    $display("CHECK FAILED %0t %s", $time, m);
    bad_count++;
  endtask : fail
  task automatic chk1(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp) fail(m);
  endtask : chk1
  task automatic chk10(input logic [9:0] got, input logic [9:0] exp, input string m);
    tests_run++;
    if (got !== exp) fail(m);
  endtask : chk10
  task automatic chk12(input logic [11:0] got, input logic [11:0] exp, input string m);
    tests_run++;
    if (got !== exp) fail(m);
  endtask : chk12
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  task automatic pulse_clear(input logic by_transfer);
    done_p = by_transfer;
    flag_clr = !by_transfer;
    tick(1);
    {done_p, flag_clr} = 2'b00;
  endtask : pulse_clear
  // Mode and channel change only while idle, set in the same write
  task automatic start(input logic sm, input logic rp, input logic [1:0] c, k);
    {scan_mode, rep, ch, cs, set_p} = {sm, rp, c, k, 1'b1};
    tick(1);
    set_p = 1'b0;
  endtask : start
  task automatic wait_idle(output int n);
    n = 0;
    while (busy !== 1'b0) begin
      tick(1);
      n++;
      if (n > 12000) begin
        fail("timeout");
        wrap_up();
      end
    end
  endtask : wait_idle
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1) begin
      tick(1);
      n++;
      if (n > 12000) begin
        fail("timeout");
        wrap_up();
      end
    end
  endtask : wait_hi
  // ==========
  // Scenarios
  task automatic t_single;
    int n;
    for (int i = 0; i < 4; i++) begin
      dtc_sel = i[0];
      q.delete();
      start(1'b0, 1'b0, 2'(i), 2'(i));
      chk1(start_bit, 1'b1, "start bit while converting");
      wait_idle(n);
      chk1(n / 8 >= TMIN[i] && n / 8 <= TMAX[i] + 1, 1'b1, "conversion time");
      chk10(chan_data[i*10 +: 10], lvl(i), "channel data");
      chk1(start_bit, 1'b0, "start bit self clear");
      chk1(irq & end_flag, 1'b1, "flag and interrupt");
      chk1(dtc_req, i[0], "transfer controller request");
      chk1(memory_access_controller_req, !i[0], "memory access request");
      tick(3);
      chk1(q.size() == 1, 1'b1, "one word per start");
      chk12(q[0], {2'(i), lvl(i)}, "stream word");
      pulse_clear(i[0]);
      chk1(end_flag | irq, 1'b0, "flag clear");
    end
  endtask : t_single
  task automatic t_scan_once;
    int n;
    q.delete();
    start(1'b1, 1'b0, 2'h3, 2'h3);
    wait_idle(n);
    chk1(n / 8 >= 515 && n / 8 <= 519, 1'b1, "scan pass time");
    chk1(end_flag & !start_bit, 1'b1, "pass end");
    tick(3);
    for (int j = 0; j < 4; j++) begin
      chk12(q[j], {2'(j), lvl(j)}, "scan order");
      chk10(chan_data[j*10 +: 10], lvl(j), "scan data");
    end
    pulse_clear(1'b0);
  endtask : t_scan_once
  task automatic t_abort;
    got_word = 1'b0;
    start(1'b1, 1'b0, 2'h3, 2'h3);
    wait_hi(got_word);
    clr_p = 1'b1;
    tick(1);
    clr_p = 1'b0;
    chk1(busy | start_bit | end_flag, 1'b0, "abort mid pass");
  endtask : t_abort
  task automatic t_scan_cont;
    q.delete();
    ready = 1'b0;
    start(1'b1, 1'b1, 2'h3, 2'h3);
    for (int p = 0; p < 4; p++) begin
      wait_hi(end_flag);
      chk1(busy, 1'b1, "continuous keeps running");
      pulse_clear(1'b0);
    end
    // Sixteen words fill the buffer, so the next result must stall
    tick(1400);
    chk1(busy & rvalid & (q.size() == 0), 1'b1, "stalled on full buffer");
    clr_p = 1'b1;
    tick(1);
    clr_p = 1'b0;
    chk1(busy | start_bit, 1'b0, "clear stops scan");
    ready = 1'b1;
    tick(40);
    // Sixteen buffered words plus the held first word of the next pass
    chk1(q.size() == 17, 1'b1, "buffer content");
    for (int j = 0; j < 17; j++) begin
      chk12(q[j], {2'(j % 4), lvl(j % 4)}, "repeat order");
    end
  endtask : t_scan_cont
  task automatic t_trig;
    int n;
    logic exp;
    en = 1'b0;
    {scan_mode, ch, cs} = {1'b0, 2'h2, 2'h3};
    for (int s = 0; s < 4; s++) begin
      for (int t = 0; t < 2; t++) begin
        exp = t ? (s < 2) : (s == 0 || s == 2);
        src = 2'(s);
        q.delete();
        tick(1);
        if (t) pin_n = 1'b0;
        else tmr = 1'b1;
        tick(1);
        tmr = 1'b0;
        tick(6);
        pin_n = 1'b1;
        chk1(busy, exp, "trigger start");
        if (exp) begin
          tmr = 1'b1;
          tick(1);
          tmr = 1'b0;
          wait_idle(n);
          tick(3);
          chk1(q.size() == 1, 1'b1, "no restart");
          chk10(chan_data[20 +: 10], lvl(2), "triggered data");
          chk1(end_flag & !irq, 1'b1, "masked interrupt");
          pulse_clear(1'b0);
        end
      end
    end
  endtask : t_trig
  initial begin
    {set_p, clr_p, scan_mode, rep, flag_clr, tmr, dtc_sel, done_p, got_word} = '0;
    {pin_n, en, ready, ch, cs, src} = {3'b111, 2'h0, 2'h0, TRG_NONE};
    tick(3);
    rst_n = 1'b1;
    tick(2);
    t_single();
    t_scan_once();
    t_abort();
    t_scan_cont();
    t_trig();
    wrap_up();
  end
endmodule : sas_sequencer_tb
`default_nettype wire
